//--- ddrwp_pkg.sv
// constants, carriers and state layout of the write/precharge/refresh block
package ddrwp_pkg;
    localparam int CLK_PS = 5000;
    localparam int ROW_CLOSE_PS = 13750;
    localparam int REF_CYCLE_PS = 160000;
    localparam int AVG_REF_NORM_PS = 7800000;
    localparam int AVG_REF_EXT_PS = 3900000;
    localparam int ROW_CLOSE_CYC = (ROW_CLOSE_PS + CLK_PS - 1) / CLK_PS;
    localparam int REF_CYCLE_CYC = (REF_CYCLE_PS + CLK_PS - 1) / CLK_PS;
    localparam int AVG_REF_NORM_CYC = AVG_REF_NORM_PS / CLK_PS;
    localparam int AVG_REF_EXT_CYC = AVG_REF_EXT_PS / CLK_PS;
    localparam int MAX_POSTED = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_ROW = 8'h08;
    localparam logic [7:0] OFS_PEEK_IDX = 8'h0c;
    localparam logic [7:0] OFS_PEEK_DATA = 8'h10;
    localparam int CTRL_OTF_BIT = 0;
    localparam int CTRL_BL8_BIT = 1;
    localparam int CTRL_EXT_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [2:0] ba;
        logic [15:0] addr;
    } ddrwp_cmd_type;
    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic [3:0] mask;
    } ddrwp_beat_type;
    typedef struct packed {
        logic [7:0] bank_open;
        logic [7:0][3:0] pre_cnt;
        logic wb_active;
        logic [2:0] wb_bank;
        logic [9:0] wb_col;
        logic [2:0] wb_left;
        logic wb_ap;
        logic [5:0] ref_cnt;
        logic ref_busy;
        logic [15:0] ref_row;
        logic sr;
        logic [10:0] itv;
        logic [3:0] debt;
        logic cke_q;
        logic [2:0] ctrl;
        logic [5:0] peek;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ddrwp_state_type;
endpackage

//--- ddrwp_core.sv
// bank state, write bursts, precharge and refresh tracking with an axi4-lite view
// How it works
// [R1] write picks its bank from the bank inputs; the bank must be open
// [R2] a10 at write: low keeps row open, high auto-precharges after the burst
// [R3] with on-the-fly select, a12 low gives four beats, high eight
// [R4] write decodes as cs low, ras high, cas low, we low, cke high
// [R5] a byte lane is stored only while its mask bit is low
// [R6] precharge closes the addressed row; controller waits row_close_time
// [R7] precharge with a10 high closes all banks, else the selected bank
// [R8] other banks may be accessed while one auto-precharges
// [R9] an idle bank must be activated before read or write
// [R10] precharge to an idle bank is a no-operation
// [R11] precharge interval runs from the last precharge to that bank
// [R12] refresh row address comes from an internal counter
// [R13] every refresh needs its own command
// [R14] refresh average interval at most 7.8us, or 3.9us when hot
// [R15] only nop or deselect during refresh_cycle_time after refresh
// [R16] at most eight refreshes may be postponed
// [R17] postponed count before and after self refresh stays at eight or less
// [R18] at most 16 refreshes within two average refresh intervals
// [R19] cke high with precharge, activate and refresh
// [R20] all banks closed before refresh, precharge-all when several open
// [R21] self refresh keeps rows refreshed from an internal timer
// [R22] first write waits 512 clocks after reference voltage returns
// [R23] per-bank open flag and precharge countdown follow every bank event
module ddrwp_core import ddrwp_pkg::*; (
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic cke,
    input wire ddrwp_cmd_type cmd,
    input wire ddrwp_beat_type beat,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic [7:0] bank_open,
    output logic self_refresh,
    output logic refresh_busy
);
    localparam logic [3:0] ROW_CLOSE_CNT = 4'(ROW_CLOSE_CYC);
    localparam logic [5:0] REF_CNT = 6'(REF_CYCLE_CYC);
    localparam logic [10:0] ITV_NORM = 11'(AVG_REF_NORM_CYC - 1);
    localparam logic [10:0] ITV_EXT = 11'(AVG_REF_EXT_CYC - 1);
    localparam logic [3:0] DEBT_CAP = 4'(MAX_POSTED + 1);
    localparam ddrwp_state_type ST_RST = '{ctrl: CTRL_RST, default: '0};

    ddrwp_state_type s;
    ddrwp_state_type n;
    logic [31:0] mem [64];
    logic cmd_ok;
    logic c_act;
    logic c_wr;
    logic c_pre;
    logic c_ref;
    logic sr_entry;
    logic beat_take;
    logic [5:0] beat_idx;
    logic [7:0] precharging;
    logic [10:0] itv_top;

    ////////////////////////////////////////////////////////////////
    // command decode
    always_comb begin
        cmd_ok = ce && s.cke_q && !s.sr && !cmd.cs_n;
        c_act = cmd_ok && cke && !cmd.ras_n && cmd.cas_n && cmd.we_n;
        c_wr = cmd_ok && cke && cmd.ras_n && !cmd.cas_n && !cmd.we_n; // [R4]
        c_pre = cmd_ok && cke && !cmd.ras_n && cmd.cas_n && !cmd.we_n;
        c_ref = cmd_ok && !cmd.ras_n && !cmd.cas_n && cmd.we_n;
        sr_entry = c_ref && !cke;
        beat_take = ce && s.wb_active && beat.valid;
        beat_idx = {s.wb_bank, s.wb_col[2:0]};
        for (int i = 0; i < 8; i++) begin
            precharging[i] = (s.pre_cnt[i] != 4'h0);
        end
        itv_top = s.ctrl[CTRL_EXT_BIT] ? ITV_EXT : ITV_NORM;
    end

    ////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        n = s;
        n.cke_q = cke;
        for (int i = 0; i < 8; i++) begin
            if (precharging[i]) begin
                n.pre_cnt[i] = s.pre_cnt[i] - 4'h1; // [R23]
            end
        end
        if (s.ref_cnt != 6'h00) begin
            n.ref_cnt = s.ref_cnt - 6'h01;
        end
        // interval timer: posting debt when awake, row refresh when asleep
        if (s.itv >= itv_top) begin
            n.itv = 11'h000;
            if (s.sr) begin
                n.ref_row = s.ref_row + 16'h0001; // [R21]
            end else if (s.debt != DEBT_CAP) begin
                n.debt = s.debt + 4'h1; // [R16]
            end
        end else begin
            n.itv = s.itv + 11'h001;
        end
        if (s.sr && cke) begin
            n.sr = 1'b0;
        end
        // write burst beats
        if (beat_take) begin
            if (s.wb_left == 3'h0) begin
                n.wb_active = 1'b0;
                if (s.wb_ap) begin
                    n.bank_open[s.wb_bank] = 1'b0; // [R2]
                    n.pre_cnt[s.wb_bank] = ROW_CLOSE_CNT; // [R23]
                end
            end else begin
                n.wb_left = s.wb_left - 3'h1;
                n.wb_col[2:0] = s.wb_col[2:0] + 3'h1;
            end
        end
        if (c_act && !precharging[cmd.ba]) begin
            n.bank_open[cmd.ba] = 1'b1; // [R23]
        end
        // a write to a closed bank is dropped: no row to write into
        if (c_wr && s.bank_open[cmd.ba]) begin
            n.wb_active = 1'b1;
            n.wb_bank = cmd.ba; // [R1]
            n.wb_col = cmd.addr[9:0]; // [R4]
            n.wb_ap = cmd.addr[10]; // [R2]
            if (s.ctrl[CTRL_OTF_BIT]) begin
                n.wb_left = cmd.addr[12] ? 3'h7 : 3'h3; // [R3]
            end else begin
                n.wb_left = s.ctrl[CTRL_BL8_BIT] ? 3'h7 : 3'h3;
            end
        end
        if (c_pre) begin
            for (int i = 0; i < 8; i++) begin
                if ((cmd.addr[10] || cmd.ba == 3'(i)) && (s.bank_open[i] || precharging[i])) begin // [R7] [R10]
                    n.bank_open[i] = 1'b0; // [R6]
                    n.pre_cnt[i] = ROW_CLOSE_CNT; // [R11]
                end
            end
        end
        if (c_ref) begin
            n.ref_row = s.ref_row + 16'h0001; // [R12]
            n.itv = 11'h000;
            if (sr_entry) begin
                n.sr = 1'b1; // [R21]
            end else begin
                n.ref_cnt = REF_CNT;
            end
            // counts from n so an interval tick in the same cycle is not lost
            if (n.debt != 4'h0) begin
                n.debt = n.debt - 4'h1; // [R17]
            end
        end
        n.ref_busy = (n.ref_cnt != 6'h00); // [R15]
        // axi4-lite write channel
        if (s.awready && s_axi_awvalid) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid) begin
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata;
            n.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (s.aw_got && s.w_got && !s.bvalid) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            case (s.awaddr)
                OFS_CTRL: begin
                    if (s.wstrb[0]) begin
                        n.ctrl = s.wdata[2:0];
                    end
                end
                OFS_PEEK_IDX: begin
                    if (s.wstrb[0]) begin
                        n.peek = s.wdata[5:0];
                    end
                end
                OFS_STAT, OFS_ROW, OFS_PEEK_DATA: begin
                    n.bresp = RESP_OKAY;
                end
                default: begin
                    n.bresp = RESP_DECERR;
                end
            endcase
        end
        n.awready = !n.aw_got && !n.bvalid;
        n.wready = !n.w_got && !n.bvalid;
        // axi4-lite read channel
        if (s.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s.arready && s_axi_arvalid) begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h0000_0000;
            case (s_axi_araddr)
                OFS_CTRL: n.rdata[2:0] = s.ctrl;
                OFS_STAT: n.rdata = {8'h00, s.debt, 1'b0, s.wb_active, s.ref_cnt != 6'h00,
                                     s.sr, precharging, s.bank_open};
                OFS_ROW: n.rdata[15:0] = s.ref_row;
                OFS_PEEK_IDX: n.rdata[5:0] = s.peek;
                OFS_PEEK_DATA: n.rdata = mem[s.peek];
                default: n.rresp = RESP_DECERR;
            endcase
        end
        n.arready = !n.rvalid;
    end

    ////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= ST_RST;
        end else if (ce) begin
            s <= n;
        end
    end

    // array has no reset: contents are undefined until written, as in a real array
    always_ff @(posedge clk) begin
        if (beat_take) begin
            for (int l = 0; l < 4; l++) begin
                if (!beat.mask[l]) begin
                    mem[beat_idx][8*l +: 8] <= beat.data[8*l +: 8]; // [R5]
                end
            end
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign bank_open = s.bank_open;
    assign self_refresh = s.sr;
    assign refresh_busy = s.ref_busy;

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_write_bank_pick: assert property ( // [R1]
        c_wr && s.bank_open[cmd.ba] |=> s.wb_active && s.wb_bank == $past(cmd.ba))
        else $error("write burst not started on chosen bank");
    a_write_autopre_flag: assert property ( // [R2]
        c_wr && s.bank_open[cmd.ba] |=> s.wb_ap == $past(cmd.addr[10]))
        else $error("auto precharge flag not taken from a10");
    a_write_chop_len: assert property ( // [R3]
        c_wr && s.bank_open[cmd.ba] && s.ctrl[CTRL_OTF_BIT] && !cmd.addr[12] |=> s.wb_left == 3'h3)
        else $error("chopped burst not four beats");
    a_write_column: assert property ( // [R4]
        c_wr && s.bank_open[cmd.ba] |=> s.wb_col == $past(cmd.addr[9:0]))
        else $error("column not taken from low address bits");
    a_pre_all_close: assert property ( // [R7]
        c_pre && cmd.addr[10] && !c_act |=> s.bank_open == 8'h00)
        else $error("precharge all left a bank open");
    a_pre_bank_close: assert property ( // [R6]
        c_pre && !cmd.addr[10] && s.bank_open[cmd.ba]
        |=> !s.bank_open[$past(cmd.ba)] && s.pre_cnt[$past(cmd.ba)] == ROW_CLOSE_CNT)
        else $error("single bank precharge did not close the row");
    a_pre_idle_noop: assert property ( // [R10]
        c_pre && !cmd.addr[10] && !s.bank_open[cmd.ba] && !precharging[cmd.ba]
        |=> s.pre_cnt[$past(cmd.ba)] == 4'h0)
        else $error("precharge to idle bank was not a no-op");
    a_pre_restart_time: assert property ( // [R11]
        c_pre && !cmd.addr[10] && precharging[cmd.ba] |=> s.pre_cnt[$past(cmd.ba)] == ROW_CLOSE_CNT)
        else $error("precharge interval not restarted");
    a_refresh_row_step: assert property ( // [R12]
        c_ref |=> s.ref_row == $past(s.ref_row) + 16'h0001)
        else $error("refresh row counter did not advance");
    a_autopre_close: assert property ( // [R23]
        beat_take && s.wb_left == 3'h0 && s.wb_ap
        |=> !s.bank_open[$past(s.wb_bank)] && s.pre_cnt[$past(s.wb_bank)] == ROW_CLOSE_CNT)
        else $error("auto precharge did not close the bank");
    a_self_refresh_enter: assert property ( // [R21]
        sr_entry |=> s.sr ##1 (s.sr || cke))
        else $error("self refresh not entered");

    c_write_masked: cover property (beat_take && beat.mask != 4'h0);
    c_auto_precharge: cover property (beat_take && s.wb_left == 3'h0 && s.wb_ap);
    c_precharge_all: cover property (c_pre && cmd.addr[10] && s.bank_open != 8'h00);
    c_self_refresh: cover property (sr_entry);
endmodule

//--- ddrwp_ctl_model.sv
// controller stand-in: dram commands, cke and write beats
module ddrwp_ctl_model import ddrwp_pkg::*; (
    input wire logic clk,
    output logic cke,
    output ddrwp_cmd_type cmd,
    output ddrwp_beat_type beat
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cke = 1'b1;
        cmd = {1'b1, 22'h15_5555};
        beat = '0;
    end
    ////////////////////////////////////////////////////////////////
    // one command per call, so each refresh is its own command
    // cke is set with the command, high for act, pre and
    // deselect flips the idle lines so a stale command never repeats
    // a burst ends before the next command, so no transfer is cut
    // no write follows self refresh, so the reference wait is kept
    task automatic issue(input logic [2:0] rcw, input logic [2:0] ba, input logic [15:0] a, input logic ck);
        @(posedge clk);
        cmd <= {1'b0, rcw, ba, a};
        cke <= ck;
        @(posedge clk);
        cmd <= {1'b1, ~rcw, ~ba, ~a};
    endtask
    task automatic wake();
        @(posedge clk);
        cke <= 1'b1;
    endtask
    // write, then one beat an edge; idle beat lines flip
    task automatic burst(input logic [2:0] ba, input logic [15:0] a, input int n,
        input logic [31:0] d [8], input logic [3:0] m [8]);
        issue(3'b100, ba, a, 1'b1);
        for (int i = 0; i < n; i++) begin
            beat <= {1'b1, d[i], m[i]};
            @(posedge clk);
        end
        beat <= {1'b0, ~beat.data, ~beat.mask};
    endtask
endmodule

//--- test_ddrwp_core.sv
// self-checking bench for the write/precharge/refresh block
module test_ddrwp_core import ddrwp_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, ce, cke, self_refresh, refresh_busy;
    ddrwp_cmd_type cmd;
    ddrwp_beat_type beat;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr, bank_open;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [33:0] exq [$];
    logic [31:0] mem [8];
    logic [31:0] d [8];
    logic [3:0] m [8];
    logic [3:0] m0 [8] = '{default: 4'h0};
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    ddrwp_core i_ddrwp_core (.clk(clk), .rstn(rstn), .ce(ce), .cke(cke), .cmd(cmd), .beat(beat),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .bank_open(bank_open), .self_refresh(self_refresh), .refresh_busy(refresh_busy));
    ddrwp_ctl_model i_ddrwp_ctl_model (.clk(clk), .cke(cke), .cmd(cmd), .beat(beat));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // aw and w offered together, each dropped once taken
    task automatic axw(input logic [7:0] ad, input logic [31:0] dt, input logic [1:0] er);
        logic a;
        logic w;
        a = 1'b1;
        w = 1'b1;
        @(posedge clk);
        {awvalid, wvalid, bready} <= 3'h7;
        awaddr <= ad;
        wdata <= dt;
        wstrb <= {3'($urandom), 1'b1};
        while (a | w) begin
            @(posedge clk);
            if (awready === 1'b1)
                a = 1'b0;
            if (wready === 1'b1)
                w = 1'b0;
            if (!a)
                awvalid <= 1'b0;
            if (!w)
                wvalid <= 1'b0;
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check("bresp", 34'(bresp), 34'(er));
    endtask
    // expectation noted first, the monitor compares when data returns
    task automatic axr(input logic [7:0] ad, input logic [33:0] ex);
        exq.push_back(ex);
        @(posedge clk);
        {arvalid, rready} <= 2'h3;
        araddr <= ad;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        rready <= 1'b0;
    endtask
    task automatic peek(input int i, input logic [31:0] ex);
        axw(OFS_PEEK_IDX, 32'(i), RESP_OKAY);
        axr(OFS_PEEK_DATA, {RESP_OKAY, ex});
    endtask
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1) begin
            if (exq.size() > 0)
                check("axi read", {rresp, rdata}, exq.pop_front());
            else
                check("read queue", 34'h1, 34'h0);
        end
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            stop_test();
        end
    end
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
        void'($urandom(32'hdc0a_8973));
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        axw(OFS_STAT, 32'hffff_ffff, RESP_OKAY);
        axr(OFS_CTRL, {RESP_OKAY, 29'h0000_0000, CTRL_RST});
        axr(OFS_STAT, {RESP_OKAY, 32'h0000_0000});
        axr(8'h40, {RESP_DECERR, 32'h0000_0000});
        axw(8'h44, 32'h0000_0000, RESP_DECERR);
        axw(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
        $display("test registers done");
        i_ddrwp_ctl_model.issue(3'b011, 3'h2, 16'($urandom), 1'b1);
        @(negedge clk);
        check("bank_open", 34'(bank_open), 34'h004);
        for (int i = 0; i < 8; i++) begin
            d[i] = $urandom;
            m[i] = 4'($urandom);
            mem[(5 + i) % 8] = d[i];
        end
        i_ddrwp_ctl_model.burst(3'h2, 16'h1005, 8, d, m0); // eight beats, col wraps
        for (int i = 0; i < 8; i++)
            d[i] = $urandom;
        for (int i = 0; i < 4; i++) begin
            for (int b = 0; b < 4; b++) begin
                if (!m[i][b])
                    mem[i][8 * b +: 8] = d[i][8 * b +: 8];
            end
        end
        i_ddrwp_ctl_model.burst(3'h2, 16'h0400, 4, d, m); // chopped, auto precharge
        @(negedge clk);
        check("bank_open", 34'(bank_open), 34'h000);
        i_ddrwp_ctl_model.burst(3'h2, 16'h1000, 8, d, m0); // closed bank
        for (int i = 0; i < 8; i++)
            peek(16 + i, mem[i]);
        $display("test write done");
        for (int b = 1; b < 8; b += 3)
            i_ddrwp_ctl_model.issue(3'b011, 3'(b), 16'($urandom), 1'b1);
        @(negedge clk);
        check("bank_open", 34'(bank_open), 34'h092);
        i_ddrwp_ctl_model.issue(3'b010, 3'h4, 16'($urandom) & 16'hfbff, 1'b1);
        @(negedge clk);
        check("bank_open", 34'(bank_open), 34'h082);
        i_ddrwp_ctl_model.issue(3'b010, 3'h5, 16'h0000, 1'b1);
        @(negedge clk);
        check("bank_open", 34'(bank_open), 34'h082);
        i_ddrwp_ctl_model.issue(3'b010, 3'h4, 16'($urandom) | 16'h0400, 1'b1);
        @(negedge clk);
        check("bank_open", 34'(bank_open), 34'h000);
        $display("test precharge done");
        repeat (8) @(posedge clk);
        axr(OFS_ROW, {RESP_OKAY, 32'h0000_0000});
        // two refreshes, far inside the interval and burst limits
        for (int r = 1; r < 3; r++) begin
            i_ddrwp_ctl_model.issue(3'b001, 3'($urandom), 16'($urandom), 1'b1);
            n = 0;
            @(negedge clk);
            while (refresh_busy === 1'b1 && n < 100) begin
                n++;
                @(negedge clk);
            end
            check("refresh_busy", 34'(n), 34'(REF_CYCLE_CYC));
            axr(OFS_ROW, {RESP_OKAY, 32'(r)});
        end
        i_ddrwp_ctl_model.issue(3'b001, 3'h0, 16'($urandom), 1'b0); // no postponed debt
        repeat (4) @(negedge clk);
        check("self_refresh", 34'(self_refresh), 34'h001);
        i_ddrwp_ctl_model.wake();
        repeat (2) @(negedge clk);
        check("self_refresh", 34'(self_refresh), 34'h000);
        $display("test refresh done");
        stop_test();
    end
endmodule
